// >>> hdl/mmcd_pkg.sv
// Constants, field layouts and carrier types for the manual command decoder.
package mmcd_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_AXES  = 4;
  localparam int NUM_TASKS = 4;
  localparam int WORD_W    = 16;
  localparam int CMD_W     = 10;

  // ---------------------------------------------------------------------------
  // Bit positions inside the task control word and the axis command word
  // ---------------------------------------------------------------------------
  localparam int BIT_MODE   = 1;
  localparam int BIT_DECEL  = 0;
  localparam int BIT_SEARCH = 1;
  localparam int BIT_RETURN = 2;
  localparam int BIT_JOG    = 3;
  localparam int BIT_ECR    = 4;
  localparam int BIT_FORCED = 5;
  localparam int BIT_ABS    = 6;
  localparam int BIT_FOLLOW = 8;
  localparam int BIT_LOCK   = 9;
  localparam int BIT_UNLOCK = 10;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST     = 16'h0000;
  localparam int                INIT_TIME_US = 100;
  localparam int                CLK_HZ       = 10_000_000;
  localparam int                INIT_CNT_W   = 11;
  localparam logic [INIT_CNT_W-1:0] INIT_COUNT =
    INIT_CNT_W'(INIT_TIME_US * (CLK_HZ / 1_000_000));

  // ---------------------------------------------------------------------------
  // Command masks, laid out as the command struct below (MSB is highest)
  // ---------------------------------------------------------------------------
  localparam logic [CMD_W-1:0] MASK_ANY_MODE = 10'h280;
  localparam logic [CMD_W-1:0] MASK_DECEL    = 10'h100;
  localparam logic [CMD_W-1:0] MASK_HOLD     = 10'h072;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef logic [WORD_W-1:0] mmcd_word_t;

  // Field order is the priority order, highest first.
  typedef struct packed {
    logic unlock;
    logic decel;
    logic ecr;
    logic search;
    logic ret;
    logic jog;
    logic forced;
    logic abs_set;
    logic handwheel_follow;
    logic lock;
  } mmcd_cmd_s;

  typedef struct packed {
    logic [1:0]  axis;
    logic [31:0] value;
  } mmcd_preset_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_SHOT = 3'b100
  } mmcd_axis_st_e;

endpackage : mmcd_pkg

// >>> hdl/mmcd_decoder.sv
// Host control word decoder: initialisation, task modes and manual axis commands.
`timescale 1ns/1ps

// Summary of operation
// - Commands are ignored while initial processing runs.
// - Initialisation flag is on during initial processing, off afterwards.
// - Bit 01 of each task word selects automatic (1) or manual (0).
// - Mode bit rising stops the task's own axis in manual operation.
// - Mode bit falling halts the task program and stops its axis.
// - Edges are found inside the block by sampling the shared words.
// - One command word per axis; bit 10 rising requests servo-unlock.
// - Manual commands start only on a rising edge of their bit.
// - Simultaneous rising commands resolve by fixed priority, unlock highest.
// - Bit 00 rising starts a deceleration stop of the axis.
// - Decel bit held in manual mode refuses axis commands other than error counter reset and servo-unlock.
// - Bit 04 rising clears the axis position error counter.
// - Bit 01 rising starts origin search, falling stops it.
// - Bit 02 rising starts reference origin return, falling stops it.
// - Search, return, jog, handwheel follow run while bit stays one.
// - Bits 05, 06, 09 rising start forced origin, absolute origin, lock.
// - Error counter reset and servo-unlock are accepted in automatic mode.
// - Position preset arrives as a block data write, not a bit.
// - Busy while a command runs; only deceleration stop accepted then.
module mmcd_decoder (
  input  wire logic                                      i_ref_clk,
  input  wire logic                                      i_rst_n,
  input  wire logic                                      i_restart,
  input  wire logic                                      i_refresh,
  input  wire mmcd_pkg::mmcd_word_t [3:0]                i_task_word,
  input  wire mmcd_pkg::mmcd_word_t [3:0]                i_axis_word,
  input  wire logic [3:0]                                i_cmd_done,
  input  wire logic                                      i_preset_valid,
  input  wire mmcd_pkg::mmcd_preset_s                    i_preset,
  output logic                                           o_init_flag,
  output logic [3:0]                                     o_task_auto,
  output logic [3:0]                                     o_prog_halt,
  output mmcd_pkg::mmcd_cmd_s [3:0]                      o_axis_start,
  output logic [3:0]                                     o_axis_stop,
  output logic [3:0]                                     o_axis_busy,
  output logic                                           o_preset_valid,
  output mmcd_pkg::mmcd_preset_s                         o_preset
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Maps word bits onto the command struct in priority order.
  function automatic mmcd_pkg::mmcd_cmd_s to_cmd(input mmcd_pkg::mmcd_word_t w);
    mmcd_pkg::mmcd_cmd_s c;
    c.unlock           = w[mmcd_pkg::BIT_UNLOCK];
    c.decel            = w[mmcd_pkg::BIT_DECEL];
    c.ecr              = w[mmcd_pkg::BIT_ECR];
    c.search           = w[mmcd_pkg::BIT_SEARCH];
    c.ret              = w[mmcd_pkg::BIT_RETURN];
    c.jog              = w[mmcd_pkg::BIT_JOG];
    c.forced           = w[mmcd_pkg::BIT_FORCED];
    c.abs_set          = w[mmcd_pkg::BIT_ABS];
    c.handwheel_follow = w[mmcd_pkg::BIT_FOLLOW];
    c.lock             = w[mmcd_pkg::BIT_LOCK];
    return c;
  endfunction : to_cmd
  // Word bit that keeps a continuing command alive.
  function automatic mmcd_pkg::mmcd_word_t hold_bits(input mmcd_pkg::mmcd_cmd_s c);
    mmcd_pkg::mmcd_word_t w;
    w                         = mmcd_pkg::WORD_RST;
    w[mmcd_pkg::BIT_SEARCH]   = c.search;
    w[mmcd_pkg::BIT_RETURN]   = c.ret;
    w[mmcd_pkg::BIT_JOG]      = c.jog;
    w[mmcd_pkg::BIT_FOLLOW]   = c.handwheel_follow;
    return w;
  endfunction : hold_bits
  // Keeps only the highest-priority request.
  function automatic mmcd_pkg::mmcd_cmd_s pick(input mmcd_pkg::mmcd_cmd_s r);
    logic [mmcd_pkg::CMD_W-1:0] v;
    logic                       found;
    v     = '0;
    found = 1'b0;
    for (int i = mmcd_pkg::CMD_W - 1; i >= 0; i--) begin
      if (r[i] && !found) begin
        v[i]  = 1'b1;
        found = 1'b1;
      end
    end
    return mmcd_pkg::mmcd_cmd_s'(v);
  endfunction : pick

  // ---------------------------------------------------------------------------
  // Restart request synchroniser
  // ---------------------------------------------------------------------------
  logic                               restart_s1_q;
  logic                               restart_s2_q;
  logic                               restart_prev_q;
  logic                               restart_rise;
  // The request comes from the host's clock, so it is brought in through two stages.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      restart_s1_q   <= 1'b0;
      restart_s2_q   <= 1'b0;
      restart_prev_q <= 1'b0;
    end else begin
      restart_s1_q   <= i_restart;
      restart_s2_q   <= restart_s1_q;
      restart_prev_q <= restart_s2_q;
    end
  end

  assign restart_rise = restart_s2_q & ~restart_prev_q;

  // ---------------------------------------------------------------------------
  // Initial processing
  // ---------------------------------------------------------------------------
  logic                               init_q;
  logic [mmcd_pkg::INIT_CNT_W-1:0]    init_cnt_q;
  logic                               live;
  // Runs for a fixed count after reset release or restart; the flag follows it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q     <= 1'b1;
      init_cnt_q <= mmcd_pkg::INIT_COUNT;
    end else if (restart_rise) begin
      init_q     <= 1'b1;
      init_cnt_q <= mmcd_pkg::INIT_COUNT;
    end else if (init_q) begin
      init_cnt_q <= init_cnt_q - 1'b1;
      if (init_cnt_q == mmcd_pkg::INIT_CNT_W'(1)) begin
        init_q <= 1'b0;
      end
    end
  end

  assign o_init_flag = init_q;
  // Refreshes during initial processing are not decoded at all.
  assign live = i_refresh & ~init_q;

  // ---------------------------------------------------------------------------
  // Previous samples of the shared words
  // ---------------------------------------------------------------------------
  mmcd_pkg::mmcd_word_t [3:0]         task_prev_q;
  mmcd_pkg::mmcd_word_t [3:0]         axis_prev_q;
  // Cleared during init so a bit already high afterwards is seen as a new edge.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      task_prev_q <= '0;
      axis_prev_q <= '0;
    end else if (init_q) begin
      task_prev_q <= '0;
      axis_prev_q <= '0;
    end else if (i_refresh) begin
      task_prev_q <= i_task_word;
      axis_prev_q <= i_axis_word;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-axis decode (axis k is owned by task k)
  // ---------------------------------------------------------------------------
  mmcd_pkg::mmcd_axis_st_e [3:0]      st_q;
  mmcd_pkg::mmcd_word_t [3:0]         run_mask_q;
  mmcd_pkg::mmcd_cmd_s [3:0]          req;
  mmcd_pkg::mmcd_cmd_s [3:0]          grant;
  logic [3:0]                         manual;
  logic [3:0]                         mode_up;
  logic [3:0]                         mode_dn;
  logic [3:0]                         stop;
  // Masks are applied from widest to narrowest so the busy gate has the last word.
  always_comb begin
    for (int a = 0; a < mmcd_pkg::NUM_AXES; a++) begin
      manual[a]  = ~i_task_word[a][mmcd_pkg::BIT_MODE];
      o_axis_busy[a] = (st_q[a] != mmcd_pkg::ST_IDLE);
      mode_up[a] = live & i_task_word[a][mmcd_pkg::BIT_MODE]
                   & ~task_prev_q[a][mmcd_pkg::BIT_MODE];
      mode_dn[a] = live & ~i_task_word[a][mmcd_pkg::BIT_MODE]
                   & task_prev_q[a][mmcd_pkg::BIT_MODE];
      req[a]     = to_cmd(i_axis_word[a] & ~axis_prev_q[a]);
      if (!manual[a]) begin
        req[a] = mmcd_pkg::mmcd_cmd_s'(req[a] & mmcd_pkg::MASK_ANY_MODE);
      end else if (i_axis_word[a][mmcd_pkg::BIT_DECEL] &
                   axis_prev_q[a][mmcd_pkg::BIT_DECEL]) begin
        req[a] = mmcd_pkg::mmcd_cmd_s'(req[a] & mmcd_pkg::MASK_ANY_MODE);
      end
      if (st_q[a] != mmcd_pkg::ST_IDLE) begin
        req[a] = mmcd_pkg::mmcd_cmd_s'(req[a] & mmcd_pkg::MASK_DECEL);
      end
      grant[a] = live ? pick(req[a]) : mmcd_pkg::mmcd_cmd_s'('0);
      // A continuing operation ends when its own bit reads zero at a refresh.
      stop[a]  = grant[a].decel | mode_up[a] | mode_dn[a]
                 | (live & (st_q[a] == mmcd_pkg::ST_HOLD)
                    & ((i_axis_word[a] & run_mask_q[a]) == mmcd_pkg::WORD_RST));
    end
  end

  // Axis operation state; one-shot commands cannot be interrupted, only finished.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q       <= {mmcd_pkg::NUM_AXES{mmcd_pkg::ST_IDLE}};
      run_mask_q <= '0;
    end else begin
      for (int a = 0; a < mmcd_pkg::NUM_AXES; a++) begin
        case (st_q[a])
          mmcd_pkg::ST_IDLE: begin
            if (|(grant[a] & mmcd_pkg::MASK_HOLD)) begin
              st_q[a]       <= mmcd_pkg::ST_HOLD;
              run_mask_q[a] <= hold_bits(grant[a]);
            end else if (|(grant[a] & ~mmcd_pkg::MASK_DECEL)) begin
              st_q[a] <= mmcd_pkg::ST_SHOT;
            end
          end
          mmcd_pkg::ST_HOLD: begin
            if (stop[a]) begin
              st_q[a] <= mmcd_pkg::ST_IDLE;
            end
          end
          mmcd_pkg::ST_SHOT: begin
            if (i_cmd_done[a]) begin
              st_q[a] <= mmcd_pkg::ST_IDLE;
            end
          end
          default: begin
            st_q[a] <= mmcd_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registered command and mode outputs
  // ---------------------------------------------------------------------------
  // Start and stop strobes last one cycle, one cycle after the refresh.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axis_start <= '0;
      o_axis_stop  <= '0;
      o_prog_halt  <= '0;
      o_task_auto  <= '0;
    end else begin
      o_axis_start <= grant;
      o_axis_stop  <= stop;
      o_prog_halt  <= mode_dn;
      for (int t = 0; t < mmcd_pkg::NUM_TASKS; t++) begin
        if (live) begin
          o_task_auto[t] <= i_task_word[t][mmcd_pkg::BIT_MODE];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Position preset by block data write
  // ---------------------------------------------------------------------------
  // The preset is a data transfer, not a control bit, and only lands on an idle manual axis.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_preset_valid <= 1'b0;
      o_preset       <= '0;
    end else begin
      o_preset_valid <= i_preset_valid & ~init_q & manual[i_preset.axis]
                        & (st_q[i_preset.axis] == mmcd_pkg::ST_IDLE);
      if (i_preset_valid) begin
        o_preset <= i_preset;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_init_ignore;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      init_q |=> (o_axis_start == '0);
  endproperty
  a_init_ignore: assert property (p_init_ignore) else $error("command during init");
  property p_init_end;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      $fell(o_init_flag) |-> ($past(init_cnt_q) == mmcd_pkg::INIT_CNT_W'(1));
  endproperty
  a_init_end: assert property (p_init_end) else $error("init ended early");
  for (genvar g = 0; g < mmcd_pkg::NUM_AXES; g++) begin : g_chk
    property p_mode_up_stop;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        mode_up[g] && st_q[g] == mmcd_pkg::ST_HOLD
        |=> o_axis_stop[g] && st_q[g] == mmcd_pkg::ST_IDLE;
    endproperty
    a_mode_up_stop: assert property (p_mode_up_stop) else $error("manual op kept");
    property p_mode_dn_halt;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        live && !i_task_word[g][mmcd_pkg::BIT_MODE] && task_prev_q[g][mmcd_pkg::BIT_MODE]
        |=> o_prog_halt[g] && o_axis_stop[g] ##1 !o_prog_halt[g];
    endproperty
    a_mode_dn_halt: assert property (p_mode_dn_halt) else $error("no program halt");
    property p_jog_edge;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_axis_start[g].jog |-> $past(live) && $past(i_axis_word[g][mmcd_pkg::BIT_JOG])
                                && !$past(axis_prev_q[g][mmcd_pkg::BIT_JOG]);
    endproperty
    a_jog_edge: assert property (p_jog_edge) else $error("jog without edge");
    property p_one_cmd;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        $onehot0(o_axis_start[g]);
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("two commands at once");
    property p_decel_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        live && manual[g] && i_axis_word[g][mmcd_pkg::BIT_DECEL]
        && axis_prev_q[g][mmcd_pkg::BIT_DECEL]
        |=> (o_axis_start[g] & ~mmcd_pkg::MASK_ANY_MODE) == '0;
    endproperty
    a_decel_hold: assert property (p_decel_hold) else $error("command under decel");
    property p_hold_end;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        live && st_q[g] == mmcd_pkg::ST_HOLD
        && (i_axis_word[g] & run_mask_q[g]) == mmcd_pkg::WORD_RST
        |=> o_axis_stop[g] && !o_axis_busy[g];
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("op outlived its bit");
    property p_auto_only;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        live && !manual[g] |=> (o_axis_start[g] & ~mmcd_pkg::MASK_ANY_MODE) == '0;
    endproperty
    a_auto_only: assert property (p_auto_only) else $error("manual cmd in auto");
    property p_busy_gate;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_axis_busy[g] |=> (o_axis_start[g] & ~mmcd_pkg::MASK_DECEL) == '0;
    endproperty
    a_busy_gate: assert property (p_busy_gate) else $error("command while busy");
    c_jog_run: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_axis_start[g].jog ##[1:50] o_axis_stop[g]);
    c_shot_done: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      st_q[g] == mmcd_pkg::ST_SHOT ##1 st_q[g] == mmcd_pkg::ST_IDLE);
    c_auto_ecr: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_task_auto[g] && o_axis_start[g].ecr);
  end

endmodule : mmcd_decoder

// >>> bench/mmcd_host_model.sv
// Host controller model that issues I/O refresh strobes on request.
`timescale 1ns/1ps
module mmcd_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_init_flag,
  input  wire logic i_go,
  input  wire logic i_early,
  output logic      o_refresh
);
  // One strobe per request, held back while the unit initialises.
  // The early input breaks that on purpose for a single scenario.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_refresh <= 1'h0;
    end else begin
      o_refresh <= i_go & (~i_init_flag | i_early);
    end
  end
endmodule : mmcd_host_model

// >>> bench/tb_top.sv
// Self-checking bench for the manual command decoder.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [15:0] aw;
    logic        dn;
    logic [9:0]  st;
    logic [1:0]  sp;
    logic        bz;
  } mmcd_row_s;
  // Axis 0 sequence; sp 2 skips the stop check where an idle axis may pulse it.
  localparam mmcd_row_s ROWS [0:23] = '{
    '{16'h0008, 1'h0, 10'h010, 2'h0, 1'h1}, '{16'h0008, 1'h0, 10'h000, 2'h0, 1'h1},
    '{16'h0000, 1'h0, 10'h000, 2'h1, 1'h0}, '{16'h0002, 1'h0, 10'h040, 2'h0, 1'h1},
    '{16'h0000, 1'h0, 10'h000, 2'h1, 1'h0}, '{16'h0004, 1'h0, 10'h020, 2'h0, 1'h1},
    '{16'h0005, 1'h0, 10'h100, 2'h1, 1'h0}, '{16'h0009, 1'h0, 10'h000, 2'h2, 1'h0},
    '{16'h0019, 1'h0, 10'h080, 2'h2, 1'h1}, '{16'h0018, 1'h1, 10'h000, 2'h2, 1'h0},
    '{16'h0000, 1'h0, 10'h000, 2'h2, 1'h0}, '{16'h0660, 1'h0, 10'h200, 2'h0, 1'h1},
    '{16'h0000, 1'h1, 10'h000, 2'h0, 1'h0}, '{16'h0360, 1'h0, 10'h008, 2'h0, 1'h1},
    '{16'h0000, 1'h1, 10'h000, 2'h0, 1'h0}, '{16'h0340, 1'h0, 10'h004, 2'h0, 1'h1},
    '{16'h0000, 1'h1, 10'h000, 2'h0, 1'h0}, '{16'h0300, 1'h0, 10'h002, 2'h0, 1'h1},
    '{16'h0200, 1'h0, 10'h000, 2'h1, 1'h0}, '{16'h0000, 1'h0, 10'h000, 2'h0, 1'h0},
    '{16'h0200, 1'h0, 10'h001, 2'h0, 1'h1}, '{16'h0208, 1'h0, 10'h000, 2'h0, 1'h1},
    '{16'h0201, 1'h0, 10'h100, 2'h1, 1'h1}, '{16'h0000, 1'h1, 10'h000, 2'h2, 1'h0}
  };
  logic                       clk, rst_n, restart, refresh, go, early, pv, init_o, pvo;
  logic [3:0]                 done, auto_o, halt_o, stop_o, busy_o, sp, hl;
  mmcd_pkg::mmcd_word_t [3:0] tw, aw;
  mmcd_pkg::mmcd_cmd_s [3:0]  start_o, st;
  mmcd_pkg::mmcd_preset_s     pre, preo;
  int                         failures, num_checks, cycles;

  mmcd_decoder mmcd_decoder_i (
    .i_ref_clk      (clk),
    .i_rst_n        (rst_n),
    .i_restart      (restart),
    .i_refresh      (refresh),
    .i_task_word    (tw),
    .i_axis_word    (aw),
    .i_cmd_done     (done),
    .i_preset_valid (pv),
    .i_preset       (pre),
    .o_init_flag    (init_o),
    .o_task_auto    (auto_o),
    .o_prog_halt    (halt_o),
    .o_axis_start   (start_o),
    .o_axis_stop    (stop_o),
    .o_axis_busy    (busy_o),
    .o_preset_valid (pvo),
    .o_preset       (preo)
  );
  mmcd_host_model mmcd_host_model_i (
    .i_ref_clk   (clk),
    .i_rst_n     (rst_n),
    .i_init_flag (init_o),
    .i_go        (go),
    .i_early     (early),
    .o_refresh   (refresh)
  );

  // Free-running clock at 100 ns.
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // A hang is cut short well above the roughly 2100 cycles that the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Outputs stand one cycle, so they are captured just after the taking edge.
  task automatic do_refresh();
    go = 1'h1;
    @(posedge clk);
    #2 go = 1'h0;
    @(posedge clk);
    #2;
    st = start_o;
    sp = stop_o;
    hl = halt_o;
  endtask : do_refresh
  task automatic pulse_done(input int k);
    done[k] = 1'h1;
    @(posedge clk);
    #2 done[k] = 1'h0;
  endtask : pulse_done
  task automatic send_preset();
    pre = '{2'h2, 32'h1234_5678};
    pv = 1'h1;
    @(posedge clk);
    #2 pv = 1'h0;
  endtask : send_preset
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Main sequence: reset and init length, table rows, then mode, preset and restart cases.
  initial begin
    {rst_n, restart, go, early, pv} = 5'h00;
    tw = '0;
    aw = '0;
    done = 4'h0;
    pre = '0;
    repeat (16) @(posedge clk);
    #2;
    check("init_flag", 16'h0001, 16'(init_o));
    check("axis_busy", 16'h0000, 16'(busy_o));
    rst_n = 1'h1;
    repeat (999) @(posedge clk);
    #2;
    check("init_flag", 16'h0001, 16'(init_o));
    @(posedge clk);
    #2;
    check("init_flag", 16'h0000, 16'(init_o));
    for (int r = 0; r < 24; r++) begin
      if (ROWS[r].dn) begin
        pulse_done(0);
      end
      aw[0] = ROWS[r].aw;
      do_refresh();
      check("axis_start", 16'(ROWS[r].st), 16'(st[0]));
      if (ROWS[r].sp != 2'h2) begin
        check("axis_stop", 16'(ROWS[r].sp), 16'(sp[0]));
      end
      check("axis_busy", 16'(ROWS[r].bz), 16'(busy_o[0]));
    end
    // Entering automatic mode stops a running jog and refuses new manual motion.
    aw[0] = 16'h0008;
    do_refresh();
    tw[0] = 16'h0002;
    do_refresh();
    check("axis_stop", 16'h0001, 16'(sp[0]));
    check("task_auto", 16'h0001, 16'(auto_o[0]));
    check("axis_busy", 16'h0000, 16'(busy_o[0]));
    aw[0] = 16'h0000;
    do_refresh();
    aw[0] = 16'h0008;
    do_refresh();
    check("axis_start", 16'h0000, 16'(st[0]));
    aw[0] = 16'h0018;
    do_refresh();
    check("axis_start", 16'h0080, 16'(st[0]));
    pulse_done(0);
    tw[0] = 16'h0000;
    do_refresh();
    check("prog_halt", 16'h0001, 16'(hl[0]));
    check("axis_stop", 16'h0001, 16'(sp[0]));
    check("task_auto", 16'h0000, 16'(auto_o[0]));
    // Preset arrives only as a block write and is refused in automatic mode.
    send_preset();
    check("preset_valid", 16'h0001, 16'(pvo));
    check("preset_value", 16'h5678, preo.value[15:0]);
    tw[2] = 16'h0002;
    do_refresh();
    send_preset();
    check("preset_valid", 16'h0000, 16'(pvo));
    // Restart: an early refresh is ignored, and a bit held through init rises afterwards.
    aw[3] = 16'h0008;
    restart = 1'h1;
    repeat (5) @(posedge clk);
    #2;
    check("init_flag", 16'h0001, 16'(init_o));
    early = 1'h1;
    do_refresh();
    early = 1'h0;
    check("axis_start", 16'h0000, 16'(st[3]));
    restart = 1'h0;
    for (int i = 0; i < 1100 && init_o !== 1'h0; i++) begin
      @(posedge clk);
      #2;
    end
    do_refresh();
    check("axis_start", 16'h0010, 16'(st[3]));
    complete_run();
  end
endmodule : tb_top
